// File: rtl/vmec_pkg.sv
// constants for the entry state checker: word map, control bits, masks
package vmec_pkg;

  // word indices, byte address is four times the index
  localparam logic [5:0] W_CTRL     = 6'h00;
  localparam logic [5:0] W_START    = 6'h01;
  localparam logic [5:0] W_STATUS   = 6'h02;
  localparam logic [5:0] W_H_CR0    = 6'h04;
  localparam logic [5:0] W_H_CR4    = 6'h06;
  localparam logic [5:0] W_H_CR3    = 6'h08;
  localparam logic [5:0] W_H_EFER   = 6'h0A;
  localparam logic [5:0] W_H_PAT    = 6'h0C;
  localparam logic [5:0] W_H_PERF   = 6'h0E;
  localparam logic [5:0] W_H_FSP    = 6'h10;
  localparam logic [5:0] W_H_FIP    = 6'h12;
  localparam logic [5:0] W_H_FS     = 6'h14;
  localparam logic [5:0] W_H_GS     = 6'h16;
  localparam logic [5:0] W_H_GDT    = 6'h18;
  localparam logic [5:0] W_H_IDT    = 6'h1A;
  localparam logic [5:0] W_H_TR     = 6'h1C;
  localparam logic [5:0] W_H_RIP    = 6'h1E;
  localparam logic [5:0] W_G_CR0    = 6'h20;
  localparam logic [5:0] W_G_CR4    = 6'h22;
  localparam logic [5:0] W_G_CR3    = 6'h24;
  localparam logic [5:0] W_G_DBGCTL = 6'h26;
  localparam logic [5:0] W_G_DR7    = 6'h28;
  localparam logic [5:0] W_G_FSP    = 6'h2A;
  localparam logic [5:0] W_G_FIP    = 6'h2C;
  localparam logic [5:0] W_G_PAT    = 6'h2E;
  localparam logic [5:0] W_G_EFER   = 6'h30;
  localparam logic [5:0] W_G_PERF   = 6'h32;
  localparam logic [5:0] W_SEL      = 6'h34;
  localparam logic [5:0] W_CR0_FIX0 = 6'h38;
  localparam logic [5:0] W_CR0_FIX1 = 6'h39;
  localparam logic [5:0] W_CR4_FIX0 = 6'h3A;
  localparam logic [5:0] W_CR4_FIX1 = 6'h3B;
  localparam int         NUM_WORDS  = 60;
  localparam int         NUM_SEL    = 7;

  // control word bit positions
  localparam int C_HOST_SIZE  = 0;
  localparam int C_LM_GUEST   = 1;
  localparam int C_LD_H_PAT   = 2;
  localparam int C_LD_G_PAT   = 3;
  localparam int C_LD_H_EFER  = 4;
  localparam int C_LD_G_EFER  = 5;
  localparam int C_LD_DEBUG   = 6;
  localparam int C_LD_H_PERF  = 7;
  localparam int C_LD_G_PERF  = 8;
  localparam int C_PRIM_SEC   = 9;
  localparam int C_UNRESTRICT = 10;
  localparam int C_CPU_LMA    = 11;
  localparam int C_HAS_64     = 12;
  localparam int C_PAW_LO     = 16;
  localparam int LIN_WIDTH    = 48;

  // field bit positions
  localparam int B_PE = 0;
  localparam int B_PG = 31;
  localparam int B_PAE = 5;
  localparam int B_PROCESS_CONTEXT_ID_ENABLE = 17;
  localparam int B_LME = 8;
  localparam int B_LMA = 10;

  localparam logic [31:0] CR0_NEVER   = 32'h6000_0000;
  localparam logic [31:0] CR0_UNRESTR = 32'h8000_0001;
  localparam logic [63:0] EFER_RSVD   = 64'hFFFF_FFFF_FFFF_F2FE;
  localparam logic [63:0] DBGCTL_RSVD = 64'hFFFF_FFFF_FFFF_0000;
  localparam logic [63:0] PERF_RSVD   = 64'hFFFF_FFF8_FFFF_FF00;
  localparam logic [31:0] CTRL_RESET  = 32'h0034_0000;

  // failure codes
  localparam logic [1:0] FAIL_NONE  = 2'h0;
  localparam logic [1:0] FAIL_HOST  = 2'h1;
  localparam logic [1:0] FAIL_GUEST = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_HOST, ST_GUEST} vmec_state_t;

endpackage

// File: rtl/vmec_checker.sv
// entry state checker: field store over APB, host then guest consistency checks
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
module vmec_checker
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         busy,
  output logic                         entry_pass,
  output logic                         entry_fail,
  output logic      [1:0]              fail_code,
  output logic                         guest_load,
  output logic                         monitor_clear,
  output logic                         host_reload
);
  import vmec_pkg::*;

  //------------------------------------------------------------
  // storage and bus decode
  //------------------------------------------------------------
  logic [31:0]  words [NUM_WORDS];
  vmec_state_t  state;
  logic [5:0]   idx;
  logic         acc;
  logic         mapped;
  logic         host_bad;
  logic         guest_bad;
  logic         start;

  assign idx    = paddr[7:2];
  assign acc    = psel & penable & pready;
  assign mapped = (32'(idx) < NUM_WORDS);
  assign start  = acc & pwrite & (idx == W_START) & pwdata[0] & (state == ST_IDLE);

  // helpers for the host and guest stages, sel for the host stage only; all are pure functions
  // of the field store, so both stages see the same decode of a field.
  // the store is frozen while busy, so the checks never see a field that
  // software is halfway through rewriting.
  // two words form one 64-bit field
  function automatic logic [63:0] f64(input logic [5:0] i);
    f64 = {words[i + 6'd1], words[i]};
  endfunction

  // addresses whose upper bits copy the top linear bit
  function automatic logic canon(input logic [63:0] a);
    canon = (a[63:LIN_WIDTH-1] == '0) || (a[63:LIN_WIDTH-1] == '1);
  endfunction

  // 63:52 clear and 51:32 clear above the width; bit 63 falls in the first range
  function automatic logic pa_ok(input logic [63:0] a, input logic [7:0] w);
    logic ok;
    ok = (a[63:52] == '0);
    for (int b = 32; b < 52; b++)
    begin
      if ((b >= int'(w)) && a[b])
      begin
        ok = 1'b0;
      end
    end
    pa_ok = ok;
  endfunction

  // every byte must be a supported memory type (2 and 3 are not)
  function automatic logic pat_ok(input logic [63:0] v);
    logic ok;
    ok = 1'b1;
    for (int b = 0; b < 8; b++)
    begin
      if ((v[8*b+3 +: 5] != '0) || (v[8*b+1 +: 2] == 2'b01))
      begin
        ok = 1'b0;
      end
    end
    pat_ok = ok;
  endfunction

  // bits that must be one or must be zero, minus the skipped ones
  function automatic logic fix_ok(input logic [31:0] v, input logic [31:0] f0,
                                  input logic [31:0] f1, input logic [31:0] skip);
    fix_ok = (((~v & f0) | (v & ~f1)) & ~skip) == '0;
  endfunction

  // one selector, two per word
  function automatic logic [15:0] sel(input int i);
    logic [31:0] w;
    w = words[W_SEL + 6'(i / 2)];
    sel = (i % 2 == 0) ? w[15:0] : w[31:16];
  endfunction

  //------------------------------------------------------------
  // host side checks
  //------------------------------------------------------------
  logic [31:0] ctl;
  logic [7:0]  paw;
  logic        hsz;
  logic        lmg;
  assign ctl = words[W_CTRL];
  assign paw = ctl[C_PAW_LO +: 8];
  assign hsz = ctl[C_HOST_SIZE];
  assign lmg = ctl[C_LM_GUEST];

  // all control and host field checks, evaluated together.
  // every check only raises host_bad, so the order of the tests below
  // does not matter and a field with several faults fails only once.
  // the address-space-size group is split by the 64-bit support bit:
  // without 64-bit support only the two size controls are looked at,
  // and the canonical and page-base checks are skipped altogether.
  // the fixed-bit masks come from software; fixed1 resets to zero, so
  // any set bit except CR0 bits 29 and 30 fails until software has loaded the masks.
  always_comb
  begin
    logic [63:0] hcr4;
    logic [63:0] hrip;
    logic [63:0] hefer;
    hcr4  = f64(W_H_CR4);
    hrip  = f64(W_H_RIP);
    hefer = f64(W_H_EFER);
    host_bad = 1'b0;
    if (!fix_ok(words[W_H_CR0], words[W_CR0_FIX0], words[W_CR0_FIX1], CR0_NEVER))
      host_bad = 1'b1;
    if (!fix_ok(hcr4[31:0], words[W_CR4_FIX0], words[W_CR4_FIX1], '0))
      host_bad = 1'b1;
    if (ctl[C_LD_H_PERF] && ((f64(W_H_PERF) & PERF_RSVD) != '0))
      host_bad = 1'b1;
    if (ctl[C_LD_H_PAT] && !pat_ok(f64(W_H_PAT)))
      host_bad = 1'b1;
    if (ctl[C_LD_H_EFER] && (((hefer & EFER_RSVD) != '0) ||
        (hefer[B_LMA] != hsz) || (hefer[B_LME] != hsz)))
      host_bad = 1'b1;
    for (int i = 0; i < NUM_SEL; i++)
    begin
      if ((sel(i) & 16'h0007) != 16'h0000)
        host_bad = 1'b1;
    end
    // order: code, stack, data, extra, fs, gs, task
    if ((sel(0) == 16'h0000) || (sel(6) == 16'h0000) || ((sel(1) == 16'h0000) && !hsz))
      host_bad = 1'b1;
    if (ctl[C_HAS_64])
    begin
      if (!pa_ok(f64(W_H_CR3), paw))
        host_bad = 1'b1;
      if (!canon(f64(W_H_FSP)) || !canon(f64(W_H_FIP)))
        host_bad = 1'b1;
      if (!canon(f64(W_H_FS)) || !canon(f64(W_H_GS)) || !canon(f64(W_H_GDT)) ||
          !canon(f64(W_H_IDT)) || !canon(f64(W_H_TR)))
        host_bad = 1'b1;
      if (!ctl[C_CPU_LMA] && (lmg || hsz))
        host_bad = 1'b1;
      if (ctl[C_CPU_LMA] && !hsz)
        host_bad = 1'b1;
      if (!hsz && (lmg || hcr4[B_PROCESS_CONTEXT_ID_ENABLE] || (hrip[63:32] != '0)))
        host_bad = 1'b1;
      if (hsz && (!hcr4[B_PAE] || !canon(hrip)))
        host_bad = 1'b1;
    end
    else if (lmg || hsz)
    begin
      host_bad = 1'b1;
    end
  end

  //------------------------------------------------------------
  // guest side checks
  //------------------------------------------------------------
  logic ug;
  // the secondary control only counts when the primary bit enables it
  assign ug = ctl[C_UNRESTRICT] & ctl[C_PRIM_SEC];

  // guest field checks; only looked at in the guest stage, after a clean
  // host stage. guest control register 0 is a 32-bit word here, the
  // upper half carries nothing that is checked.
  // the unrestricted mask only opens bits 0 and 31; the paging versus
  // protection pairing below still applies in unrestricted mode.
  // debug register high word is checked even without 64-bit support.
  always_comb
  begin
    logic [31:0] gcr0;
    logic [63:0] gcr4;
    logic [63:0] gefer;
    gcr0  = words[W_G_CR0];
    gcr4  = f64(W_G_CR4);
    gefer = f64(W_G_EFER);
    guest_bad = 1'b0;
    if (!fix_ok(gcr0, words[W_CR0_FIX0], words[W_CR0_FIX1],
                CR0_NEVER | (ug ? CR0_UNRESTR : '0)))
      guest_bad = 1'b1;
    if (!fix_ok(gcr4[31:0], words[W_CR4_FIX0], words[W_CR4_FIX1], '0))
      guest_bad = 1'b1;
    if (gcr0[B_PG] && !gcr0[B_PE])
      guest_bad = 1'b1;
    if (ctl[C_LD_DEBUG] && (((f64(W_G_DBGCTL) & DBGCTL_RSVD) != '0) ||
        (words[W_G_DR7 + 6'd1] != '0)))
      guest_bad = 1'b1;
    if (ctl[C_HAS_64])
    begin
      if (lmg && (!gcr0[B_PG] || !gcr4[B_PAE]))
        guest_bad = 1'b1;
      if (!lmg && gcr4[B_PROCESS_CONTEXT_ID_ENABLE])
        guest_bad = 1'b1;
      if (!pa_ok(f64(W_G_CR3), paw))
        guest_bad = 1'b1;
      if (!canon(f64(W_G_FSP)) || !canon(f64(W_G_FIP)))
        guest_bad = 1'b1;
    end
    if (ctl[C_LD_G_PERF] && ((f64(W_G_PERF) & PERF_RSVD) != '0))
      guest_bad = 1'b1;
    if (ctl[C_LD_G_PAT] && !pat_ok(f64(W_G_PAT)))
      guest_bad = 1'b1;
    if (ctl[C_LD_G_EFER] && (((gefer & EFER_RSVD) != '0) || (gefer[B_LMA] != lmg) ||
        (gcr0[B_PG] && (gefer[B_LMA] != gefer[B_LME]))))
      guest_bad = 1'b1;
  end

  //------------------------------------------------------------
  // APB slave: one wait state, so every answer leaves a flop
  //------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & (~mapped | (pwrite & busy));
      if (psel & penable & ~pready & ~pwrite)
      begin
        if (idx == W_STATUS)
          prdata <= {26'h0, fail_code, 1'b0, entry_pass, entry_fail, busy};
        else if (mapped && (idx != W_START))
          prdata <= words[idx];
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // field store; writes while a check runs are refused so the fields stay stable
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_WORDS; i++)
      begin
        words[i] <= 32'h0000_0000;
      end
      words[W_CTRL] <= CTRL_RESET;
    end
    else if (acc && pwrite && mapped && !busy && (idx != W_START) && (idx != W_STATUS))
    begin
      words[idx] <= pwdata;
    end
  end

  //------------------------------------------------------------
  // entry sequence
  //------------------------------------------------------------
  // host stage first; guest stage only after a clean host stage.
  // the guest stage takes one cycle: the load and monitor-clear pulses
  // go out as the guest checks are judged, so a guest failure has to
  // undo a load that already happened, hence the host reload pulse.
  // verdict levels stand until the next start so software can poll.
  // a start while busy is refused by the bus side and never seen here.
  // host stage first; guest stage only after a clean host stage
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state         <= ST_IDLE;
      busy          <= 1'b0;
      entry_pass    <= 1'b0;
      entry_fail    <= 1'b0;
      fail_code     <= FAIL_NONE;
      guest_load    <= 1'b0;
      monitor_clear <= 1'b0;
      host_reload   <= 1'b0;
    end
    else
    begin
      guest_load    <= 1'b0;
      monitor_clear <= 1'b0;
      host_reload   <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            state      <= ST_HOST;
            busy       <= 1'b1;
            entry_pass <= 1'b0;
            entry_fail <= 1'b0;
            fail_code  <= FAIL_NONE;
          end
        end
        ST_HOST:
        begin
          if (host_bad)
          begin
            state      <= ST_IDLE;
            busy       <= 1'b0;
            entry_fail <= 1'b1;
            fail_code  <= FAIL_HOST;
          end
          else
          begin
            state         <= ST_GUEST;
            guest_load    <= 1'b1;
            monitor_clear <= 1'b1;
          end
        end
        ST_GUEST:
        begin
          state <= ST_IDLE;
          busy  <= 1'b0;
          if (guest_bad)
          begin
            entry_fail  <= 1'b1;
            fail_code   <= FAIL_GUEST;
            host_reload <= 1'b1;
          end
          else
          begin
            entry_pass <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule

// File: test/vmec_checker_chk.sv
// checker: bus answer timing, verdict timing and stage order of the entry checker
`timescale 1ns/100ps
module vmec_checker_chk
  import vmec_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       busy,
  input wire logic       entry_pass,
  input wire logic       entry_fail,
  input wire logic [1:0] fail_code,
  input wire logic       guest_load,
  input wire logic       monitor_clear,
  input wire logic       host_reload
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // -------------------------------------
  // entry steps
  // -------------------------------------
  sequence s_start;
    $rose(busy);
  endsequence
  sequence s_guest;
    s_start ##1 guest_load;
  endsequence

  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  verdict_time_a: assert property (s_start |-> ##[1:2] !busy)
    else $error("verdict late");
  host_fail_a: assert property (
    s_start ##1 !guest_load |-> !busy && entry_fail && fail_code == FAIL_HOST)
    else $error("host stage verdict wrong");
  guest_end_a: assert property (
    s_guest |=> !busy && (entry_pass != entry_fail))
    else $error("guest stage verdict wrong");
  load_pair_a: assert property (
    guest_load || monitor_clear |->
      guest_load && monitor_clear && busy && !entry_pass && !entry_fail)
    else $error("load and monitor clear apart");
  guest_order_a: assert property (
    guest_load |-> $past(busy) && !$past(busy, 2))
    else $error("guest stage not right after host stage");
  reload_cause_a: assert property (
    host_reload |-> entry_fail && fail_code == FAIL_GUEST && $past(guest_load))
    else $error("host reload without guest failure");
  pass_code_a: assert property (
    entry_pass |-> !entry_fail && fail_code == FAIL_NONE)
    else $error("pass with failure code");
endmodule

bind vmec_checker vmec_checker_chk vmec_checker_chk_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .busy(busy), .entry_pass(entry_pass), .entry_fail(entry_fail),
  .fail_code(fail_code), .guest_load(guest_load), .monitor_clear(monitor_clear),
  .host_reload(host_reload)
);

// File: test/vmec_checker_tb_top.sv
// bench for the entry state checker: field mirror, verdict model, random faults
`timescale 1ns/100ps
module vmec_checker_tb_top;
  import vmec_pkg::*;
  logic        sys_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic        entry_pass;
  logic        entry_fail;
  logic [1:0]  fail_code;
  logic        guest_load;
  logic        monitor_clear;
  logic        host_reload;
  logic [31:0] mem [0:59];
  logic [31:0] rng = 32'h0000_4943;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          n_gl = 0;
  int          n_hr = 0;
  int          n_mc = 0;

  vmec_checker vmec_checker_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .entry_pass(entry_pass), .entry_fail(entry_fail), .fail_code(fail_code),
    .guest_load(guest_load), .monitor_clear(monitor_clear), .host_reload(host_reload)
  );

  // 25 ns clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // pulse tally and hang guard
  always @(posedge sys_clk)
  begin
    n_gl <= n_gl + int'(guest_load);
    n_hr <= n_hr + int'(host_reload);
    n_mc <= n_mc + int'(monitor_clear);
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_data({31'h0, got}, {31'h0, exp});
  endtask

  // xorshift source, fixed start
  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // one transfer; request held until ready is sampled, release left to the caller
  task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, i, v, d, e);
    cmp_flag(e, 1'b0);
    if (i != W_START && i != W_STATUS)
      mem[i] = v;
  endtask

  task automatic rd_chk(input logic [5:0] i, input logic [31:0] x, input logic xe);
    logic [31:0] d;
    logic        e;
    apb(1'b0, i, 32'h0, d, e);
    cmp_data(d, x);
    cmp_flag(e, xe);
  endtask

  // -------------------------------------
  // verdict model
  // -------------------------------------
  // known good field set; perf loads left off
  function automatic logic [31:0] base(int i);
    case (i)
      W_CTRL:                                          return 32'h0034_187F;
      W_H_CR0, W_G_CR0, W_CR0_FIX0:                    return 32'h8000_0001;
      W_H_CR4, W_G_CR4:                                return 32'h0000_2020;
      W_CR4_FIX0:                                      return 32'h0000_2000;
      W_CR4_FIX1:                                      return 32'h0007_FFFF;
      W_CR0_FIX1:                                      return 32'hFFFF_FFFF;
      W_H_CR3, W_G_CR3:                                return 32'h0000_1000;
      W_H_EFER, W_G_EFER:                              return 32'h0000_0500;
      W_H_PAT, W_H_PAT + 1, W_G_PAT, W_G_PAT + 1:      return 32'h0007_0406;
      W_G_DBGCTL:                                      return 32'h0000_0001;
      W_G_DR7:                                         return 32'h0000_0400;
      W_SEL:                                           return 32'h0010_0008;
      W_SEL + 1:                                       return 32'h0018_0018;
      W_SEL + 3:                                       return 32'h0000_0040;
      default:                                         return 32'h0;
    endcase
  endfunction

  function automatic logic [63:0] q(int i);
    return {mem[i + 1], mem[i]};
  endfunction

  function automatic bit cn(logic [63:0] v);
    return (&v[63:47]) || !(|v[63:47]);
  endfunction

  function automatic bit fx(logic [31:0] v, logic [31:0] f0, logic [31:0] f1, logic [31:0] sk);
    return (((~v & f0) | (v & ~f1)) & ~sk) == 32'h0;
  endfunction

  function automatic bit c3(logic [63:0] v, logic [7:0] paw);
    for (int k = 32; k < 52; k++)
      if (v[k] && k >= paw)
        return 0;
    return v[63:52] == 12'h0;
  endfunction

  function automatic bit patok(logic [63:0] v);
    for (int k = 0; k < 64; k += 8)
      if (v[k +: 8] > 8'h07 || v[k +: 8] inside {8'h02, 8'h03})
        return 0;
    return 1;
  endfunction

  function automatic logic [1:0] model();
    logic [31:0] c;
    logic [63:0] he;
    logic [63:0] ge;
    logic        hs;
    logic        lg;
    logic        pg;
    bit          h;
    bit          g;
    c = mem[W_CTRL];
    hs = c[C_HOST_SIZE];
    lg = c[C_LM_GUEST];
    pg = mem[W_G_CR0][B_PG];
    he = q(W_H_EFER);
    ge = q(W_G_EFER);
    h = fx(mem[W_H_CR0], mem[W_CR0_FIX0], mem[W_CR0_FIX1], CR0_NEVER)
      && fx(mem[W_H_CR4], mem[W_CR4_FIX0], mem[W_CR4_FIX1], 32'h0)
      && c3(q(W_H_CR3), c[23:16])
      && (!c[C_LD_H_PAT] || patok(q(W_H_PAT)))
      && (!c[C_LD_H_EFER] || ((he & EFER_RSVD) == 64'h0
          && he[B_LMA] == hs && he[B_LME] == hs))
      && ((mem[W_SEL] | mem[W_SEL + 1] | mem[W_SEL + 2]) & 32'h0007_0007) == 32'h0
      && mem[W_SEL + 3][2:0] == 3'h0
      && mem[W_SEL][15:0] != 16'h0 && mem[W_SEL + 3][15:0] != 16'h0
      && (hs || mem[W_SEL][31:16] != 16'h0)
      && cn(q(W_H_FS)) && cn(q(W_H_GS)) && cn(q(W_H_GDT)) && cn(q(W_H_IDT))
      && cn(q(W_H_TR)) && cn(q(W_H_FSP)) && cn(q(W_H_FIP))
      && ((c[C_CPU_LMA] && c[C_HAS_64]) ? hs : !hs && !lg)
      && (hs ? mem[W_H_CR4][B_PAE] && cn(q(W_H_RIP))
             : !lg && !mem[W_H_CR4][B_PROCESS_CONTEXT_ID_ENABLE] && mem[W_H_RIP + 1] == 32'h0);
    g = fx(mem[W_G_CR0], mem[W_CR0_FIX0], mem[W_CR0_FIX1],
           CR0_NEVER | ((c[C_UNRESTRICT] && c[C_PRIM_SEC]) ? CR0_UNRESTR : 32'h0))
      && !(pg && !mem[W_G_CR0][B_PE])
      && fx(mem[W_G_CR4], mem[W_CR4_FIX0], mem[W_CR4_FIX1], 32'h0)
      && (lg ? pg && mem[W_G_CR4][B_PAE] : !mem[W_G_CR4][B_PROCESS_CONTEXT_ID_ENABLE])
      && c3(q(W_G_CR3), c[23:16])
      && (!c[C_LD_DEBUG] || ((q(W_G_DBGCTL) & DBGCTL_RSVD) == 64'h0
          && mem[W_G_DR7 + 1] == 32'h0))
      && cn(q(W_G_FSP)) && cn(q(W_G_FIP))
      && (!c[C_LD_G_PAT] || patok(q(W_G_PAT)))
      && (!c[C_LD_G_EFER] || ((ge & EFER_RSVD) == 64'h0 && ge[B_LMA] == lg
          && (!pg || ge[B_LMA] == ge[B_LME])));
    return !h ? FAIL_HOST : (g ? FAIL_NONE : FAIL_GUEST);
  endfunction

  // start, poll busy off, then judge status, verdict ports and stage pulses
  task automatic run_entry();
    logic [1:0]  x;
    logic [31:0] d;
    logic        e;
    int          g0;
    int          h0;
    int          m0;
    x = model();
    g0 = n_gl;
    h0 = n_hr;
    m0 = n_mc;
    apb(1'b1, W_START, 32'h1, d, e);
    do
      apb(1'b0, W_STATUS, 32'h0, d, e);
    while (d[0] !== 1'b0);
    cmp_data(d, {26'h0, x, 1'b0, x == FAIL_NONE, x != FAIL_NONE, 1'b0});
    cmp_flag(entry_pass, x == FAIL_NONE);
    cmp_flag(entry_fail, x != FAIL_NONE);
    cmp_data({30'h0, fail_code}, {30'h0, x});
    cmp_data(n_gl - g0, {31'h0, x != FAIL_HOST});
    cmp_data(n_mc - m0, {31'h0, x != FAIL_HOST});
    cmp_data(n_hr - h0, {31'h0, x == FAIL_GUEST});
  endtask

  task automatic load_base();
    for (int k = 0; k < 60; k++)
      if (k != 1 && k != 2)
        wr(6'(k), base(k));
  endtask

  // main sequence
  initial
  begin
    logic [31:0] d;
    logic        e;
    int          i;
    int          b;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_n = 1'b0;
    foreach (mem[k])
      mem[k] = 32'h0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk(W_CTRL, CTRL_RESET, 1'b0);
    load_base();
    rd_chk(W_H_PAT + 1, 32'h0007_0406, 1'b0);
    run_entry();
    rd_chk(6'd60, 32'h0, 1'b1);
    apb(1'b1, 6'd63, 32'hFFFF_FFFF, d, e);
    cmp_flag(e, 1'b1);
    wr(W_STATUS, 32'hFFFF_FFFF);
    rd_chk(W_STATUS, 32'h0000_0004, 1'b0);
    // unrestricted guest with paging and protection off, then primary bit dropped
    wr(W_G_CR0, 32'h0);
    wr(W_G_EFER, 32'h0);
    wr(W_CTRL, 32'h0034_1E7D);
    run_entry();
    wr(W_CTRL, 32'h0034_1C7D);
    run_entry();
    load_base();
    // one random bit fault per attempt; high words of fixed-checked fields skipped
    for (int t = 0; t < 80; t++)
    begin
      i = 3 + int'(nxt() % 57);
      b = int'(nxt() % 32);
      if (i == 5 || i == 7 || i == 33 || i == 35)
        i--;
      if (i == 55)
        b = b % 16;
      wr(6'(i), base(i) ^ (32'h1 << b));
      run_entry();
      wr(6'(i), base(i));
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    print_verdict();
  end
endmodule
